// ### design/vipu_pkg.sv
package vipu_pkg;

  // Number of maskable priority levels, 0 highest.
  localparam int VIPU_LEVELS = 21;
  localparam int VIPU_IDX_W = 5;

  // Vector address of the non-maskable watchdog request.
  localparam logic [15:0] VIPU_NMI_VEC = 16'h0004;

  // Vector address of each maskable level, indexed by priority.
  localparam logic [15:0] VIPU_VEC_TABLE [VIPU_LEVELS] = '{
    16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E,
    16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A,
    16'h001C, 16'h001E, 16'h0020, 16'h0022, 16'h0024, 16'h0026,
    16'h0028, 16'h002A, 16'h002C
  };

  // Reset values.
  localparam logic [15:0] VIPU_VEC_RST = 16'h0000;
  localparam logic [VIPU_LEVELS-1:0] VIPU_FLAGS_RST = '0;

  // Request event pulses from the sources, one cycle each.
  typedef struct packed {
    logic watchdog_overflow_req;
    logic pin_edge_req0;
    logic pin_edge_req1;
    logic pin_edge_req2;
    logic pin_edge_req3;
    logic remote_edge_req;
    logic async_rx_done_req;
    logic chan_a_xfer_done_req;
    logic chan_b_xfer_done_req;
    logic async_tx_done_req;
    logic watch_tick_req;
    logic wide_timer_match_req;
    logic byte_timer1_match_req;
    logic byte_timer2_match_req;
    logic cascade_match_req;
    logic byte_timer3_match_req;
    logic conv_done_req;
    logic watch_overflow_req;
    logic key_return_req;
    logic remote_error_req;
    logic guide_pulse_req;
    logic remote_done_req;
    logic remote_shift_full_req;
  } vipu_src_s;

  // Vector presented to the processor core.
  typedef struct packed {
    logic int_req;
    logic nmi_req;
    logic [15:0] vector_addr;
  } vipu_vec_s;

  // Standby status.
  typedef struct packed {
    logic halt;
    logic stop;
    logic cpu_clock_gate;
    logic osc_stop;
    logic release_pulse;
  } vipu_stby_s;

endpackage

// ### design/vipu_top.sv
`timescale 1ns/1ps
module vipu_top (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_reset,
  // Request sources.
  input wire vipu_pkg::vipu_src_s i_src,
  // Configuration.
  input wire logic i_cascade16,
  input wire logic i_wdt_interval_mode,
  input wire logic [vipu_pkg::VIPU_LEVELS-1:0] i_mask_flag,
  input wire logic i_global_enable_flag,
  // Processor core.
  input wire logic i_ack,
  input wire logic i_halt_exec,
  input wire logic i_stop_exec,
  // Outputs.
  output vipu_pkg::vipu_vec_s o_vec,
  output vipu_pkg::vipu_stby_s o_stby,
  output logic [vipu_pkg::VIPU_LEVELS-1:0] o_req_flags
);
  import vipu_pkg::*;

  typedef struct packed {
    logic [VIPU_LEVELS-1:0] flags;
    logic nmi;
    logic [VIPU_IDX_W-1:0] win;
    vipu_vec_s vec;
    vipu_stby_s stby;
  } vipu_state_s;

  vipu_state_s st_r;
  vipu_state_s st_nxt;

  // Maps source pulses onto priority levels.
  function automatic logic [VIPU_LEVELS-1:0] map_levels(
    input vipu_src_s s, input logic casc, input logic wdt_int);
    logic [VIPU_LEVELS-1:0] v;
    v = '0;
    v[0] = s.watchdog_overflow_req & wdt_int;
    v[1] = s.pin_edge_req0;
    v[2] = s.pin_edge_req1;
    v[3] = s.pin_edge_req2;
    v[4] = s.pin_edge_req3;
    v[5] = s.remote_edge_req;
    v[6] = s.async_rx_done_req | s.chan_a_xfer_done_req;
    v[7] = s.chan_b_xfer_done_req;
    v[8] = s.async_tx_done_req;
    v[9] = s.watch_tick_req;
    v[10] = s.wide_timer_match_req;
    v[11] = s.byte_timer1_match_req;
    v[12] = casc ? s.cascade_match_req : s.byte_timer2_match_req;
    v[13] = s.byte_timer3_match_req;
    v[14] = s.conv_done_req;
    v[15] = s.watch_overflow_req;
    v[16] = s.key_return_req;
    v[17] = s.remote_error_req;
    v[18] = s.guide_pulse_req;
    v[19] = s.remote_done_req;
    v[20] = s.remote_shift_full_req;
    return v;
  endfunction

  // Returns the lowest set level, the highest priority.
  function automatic logic [VIPU_IDX_W-1:0] pick(
    input logic [VIPU_LEVELS-1:0] p);
    logic [VIPU_IDX_W-1:0] w;
    w = '0;
    for (int i = VIPU_LEVELS - 1; i >= 0; i--) begin
      if (p[i]) begin
        w = VIPU_IDX_W'(i);
      end
    end
    return w;
  endfunction

  logic [VIPU_LEVELS-1:0] set_v;
  logic [VIPU_LEVELS-1:0] clr_v;
  logic [VIPU_LEVELS-1:0] pend_v;
  logic nmi_set;
  logic wake;

  always_comb begin
    st_nxt = st_r;
    set_v = map_levels(i_src, i_cascade16, i_wdt_interval_mode);
    nmi_set = i_src.watchdog_overflow_req & ~i_wdt_interval_mode;
    clr_v = '0;
    // Acknowledge clears the presented request; a new event wins.
    if (i_ack && st_r.vec.nmi_req) begin
      st_nxt.nmi = 1'b0;
    end else if (i_ack && st_r.vec.int_req) begin
      clr_v[st_r.win] = 1'b1;
    end
    st_nxt.flags = (st_r.flags & ~clr_v) | set_v;
    if (nmi_set) begin
      st_nxt.nmi = 1'b1;
    end
    pend_v = st_nxt.flags & ~i_mask_flag;
    st_nxt.win = pick(pend_v);
    st_nxt.vec.nmi_req = st_nxt.nmi;
    st_nxt.vec.int_req = ~st_nxt.nmi & i_global_enable_flag
                         & (|pend_v);
    if (st_nxt.nmi) begin
      st_nxt.vec.vector_addr = VIPU_NMI_VEC;
    end else if (|pend_v) begin
      st_nxt.vec.vector_addr = VIPU_VEC_TABLE[st_nxt.win];
    end else begin
      st_nxt.vec.vector_addr = VIPU_VEC_RST;
    end
    // Release ignores the global enable; masked requests do not wake.
    wake = (|pend_v) | st_nxt.nmi;
    st_nxt.stby.release_pulse = wake & (st_r.stby.halt | st_r.stby.stop);
    if (wake) begin
      st_nxt.stby.halt = 1'b0;
      st_nxt.stby.stop = 1'b0;
    end else if (i_stop_exec) begin
      st_nxt.stby.stop = 1'b1;
    end else if (i_halt_exec) begin
      st_nxt.stby.halt = 1'b1;
    end
    st_nxt.stby.cpu_clock_gate = st_nxt.stby.halt | st_nxt.stby.stop;
    st_nxt.stby.osc_stop = st_nxt.stby.stop;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_vec = st_r.vec;
  assign o_stby = st_r.stby;
  assign o_req_flags = st_r.flags;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  a_wdt_one_route: assert property (
    i_src.watchdog_overflow_req && !i_wdt_interval_mode && !st_r.flags[0]
      |=> st_r.nmi && !st_r.flags[0])
    else $error("watchdog request routed wrongly");

  a_wdt_maskable: assert property (
    i_src.watchdog_overflow_req && i_wdt_interval_mode |=>
      st_r.flags[0] && !$rose(st_r.nmi))
    else $error("interval watchdog did not set level 0");

  a_nmi_vector: assert property (
    o_vec.nmi_req |-> !o_vec.int_req && o_vec.vector_addr == 16'h0004)
    else $error("non-maskable request not first");

  a_vec_prio: assert property (
    o_vec.int_req && !o_vec.nmi_req |->
      o_vec.vector_addr == 16'h0004 + {10'h000, st_r.win, 1'b0}
      && st_r.flags[st_r.win]
      && ((st_r.flags & ~$past(i_mask_flag)) &
          ((21'h000001 << st_r.win) - 21'h000001)) == '0)
    else $error("vector does not match winning level");

  a_pin3_vec: assert property (
    o_vec.int_req && st_r.win == 5'h04 |-> o_vec.vector_addr == 16'h000C)
    else $error("pin edge 3 vector wrong");

  a_shared_six: assert property (
    i_src.chan_a_xfer_done_req |=> st_r.flags[6])
    else $error("channel A end not at level 6");

  a_cascade_sel: assert property (
    i_cascade16 && i_src.cascade_match_req |=> st_r.flags[12])
    else $error("cascaded match lost");

  a_key_vec: assert property (
    o_vec.int_req && st_r.win == 5'h10 |-> o_vec.vector_addr == 16'h0024)
    else $error("key return vector wrong");

  a_ack_clear: assert property (
    i_ack && o_vec.int_req && !o_vec.nmi_req && !set_v[st_r.win]
      |=> !st_r.flags[$past(st_r.win)])
    else $error("acknowledge did not clear flag");

  a_ie_gate: assert property (
    !i_global_enable_flag |=> !o_vec.int_req)
    else $error("request presented while disabled");

  a_stop_osc: assert property (
    $rose(o_stby.osc_stop) |-> $past(i_stop_exec))
    else $error("oscillator stopped without stop");

  a_masked_sleep: assert property (
    o_stby.halt && !st_r.nmi && ((st_r.flags & ~i_mask_flag) == '0)
      && !(|map_levels(i_src, i_cascade16, i_wdt_interval_mode))
      && !i_src.watchdog_overflow_req |=> o_stby.halt)
    else $error("masked request released standby");

  a_wake_release: assert property (
    (o_stby.halt || o_stby.stop)
      && (nmi_set || (|(set_v & ~i_mask_flag))) |=>
      o_stby.release_pulse && !o_stby.halt && !o_stby.stop)
    else $error("standby not released");

  a_release_once: assert property (
    o_stby.release_pulse |=> !o_stby.release_pulse)
    else $error("standby release longer than one cycle");

endmodule

// ### tb/vipu_core_model.sv
`timescale 1ns/1ps
module vipu_core_model (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_reset,
  // Vector presented by the unit.
  input wire vipu_pkg::vipu_vec_s i_vec,
  // Acknowledge back to the unit.
  output logic o_ack
);
  import vipu_pkg::*;
  // Fetched vectors, oldest first.
  logic [15:0] seen_q[$];
  int cnt;
  always_ff @(posedge i_clock) begin
    if (i_reset || o_ack) begin
      o_ack <= 1'b0;
      cnt <= 0;
      if (o_ack && !i_reset) begin
        seen_q.push_back(i_vec.vector_addr);
      end
    end else if (i_vec.int_req || i_vec.nmi_req) begin
      cnt <= cnt + 1;
      o_ack <= (cnt == 2);
    end else begin
      cnt <= 0;
    end
  end
endmodule

// ### tb/vipu_top_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s expected %0h seen %0h", \
  n, e, g); end end
module vipu_top_bench;
  import vipu_pkg::*;
  logic i_clock = 0, i_reset = 1, i_cascade16 = 0, ack;
  logic i_wdt_interval_mode = 1, i_global_enable_flag = 1;
  logic i_halt_exec = 0, i_stop_exec = 0;
  logic [VIPU_LEVELS-1:0] i_mask_flag = '0, o_req_flags;
  logic [15:0] e;
  vipu_src_s i_src = '0;
  vipu_vec_s o_vec;
  vipu_stby_s o_stby;
  int num_errors = 0, num_checks = 0;
  initial forever #2 i_clock = ~i_clock;
  vipu_top i_vipu_top (.i_clock(i_clock), .i_reset(i_reset),
    .i_src(i_src), .i_cascade16(i_cascade16),
    .i_wdt_interval_mode(i_wdt_interval_mode), .i_mask_flag(i_mask_flag),
    .i_global_enable_flag(i_global_enable_flag), .i_ack(ack),
    .i_halt_exec(i_halt_exec), .i_stop_exec(i_stop_exec), .o_vec(o_vec),
    .o_stby(o_stby), .o_req_flags(o_req_flags));
  vipu_core_model i_vipu_core_model (.i_clock(i_clock),
    .i_reset(i_reset), .i_vec(o_vec), .o_ack(ack));
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic pulse(input logic [22:0] v);
    i_src = v;
    @(negedge i_clock);
    i_src = '0;
  endtask
  task automatic cmd(input logic h);
    i_halt_exec = h;
    i_stop_exec = !h;
    @(negedge i_clock);
    i_halt_exec = 0;
    i_stop_exec = 0;
  endtask
  task automatic drain;
    int n;
    n = 0;
    while ((o_req_flags !== '0 || o_vec.int_req !== 1'b0 ||
        o_vec.nmi_req !== 1'b0) && n < 300) begin
      @(negedge i_clock);
      n++;
    end
    if (n == 300) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic popv(input logic [15:0] x);
    logic [15:0] g;
    g = 16'hFFFF;
    if (i_vipu_core_model.seen_q.size() > 0) begin
      g = i_vipu_core_model.seen_q.pop_front();
    end
    `CHK("fetched vector", x, g)
  endtask
  // Maps a source bit of the request struct to its priority level.
  function automatic int lvl(input int b);
    if (b >= 16) return 22 - b;
    if (b == 15) return 6;
    if (b >= 9) return 21 - b;
    if (b == 8) return 12;
    return 20 - b;
  endfunction
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (3) @(negedge i_clock);
    i_reset = 0;
    @(negedge i_clock);
    `CHK("reset vec", 18'h0, o_vec)
    `CHK("reset flags", 21'h0, o_req_flags)
    for (int b = 22; b >= 0; b--) begin
      i_cascade16 = (b == 8);
      e = 16'h4 + 16'(2 * lvl(b));
      pulse(23'h1 << b);
      `CHK("flag", 21'h1 << lvl(b), o_req_flags)
      `CHK("addr", e, o_vec.vector_addr)
      drain();
      popv(e);
    end
    i_cascade16 = 0;
    i_global_enable_flag = 0;
    pulse(23'h3FFFFF);
    `CHK("pending", 21'h1FFFFE, o_req_flags)
    i_global_enable_flag = 1;
    drain();
    for (int l = 1; l <= 20; l++) popv(16'h4 + 16'(2 * l));
    i_wdt_interval_mode = 0;
    pulse(23'h600000);
    `CHK("nmi flags", 21'h2, o_req_flags)
    `CHK("nmi req", 1'b1, o_vec.nmi_req)
    `CHK("nmi addr", 16'h4, o_vec.vector_addr)
    drain();
    popv(16'h4);
    popv(16'h6);
    i_global_enable_flag = 0;
    i_mask_flag = 21'h8;
    cmd(1'b1);
    `CHK("halt", 5'b10100, o_stby)
    pulse(23'h80000);
    repeat (3) @(negedge i_clock);
    `CHK("halt hold", 5'b10100, o_stby)
    pulse(23'h10);
    `CHK("halt wake", 5'b00001, o_stby)
    `CHK("no present", 1'b0, o_vec.int_req)
    i_mask_flag = '0;
    i_global_enable_flag = 1;
    drain();
    popv(16'hA);
    popv(16'h24);
    i_global_enable_flag = 0;
    cmd(1'b0);
    `CHK("stop", 5'b01110, o_stby)
    pulse(23'h400000);
    `CHK("stop wake", 5'b00001, o_stby)
    drain();
    popv(16'h4);
    final_report();
  end
endmodule
